// file: design/ced_exec.sv
// execute-stage datapath: addressing, lanes, interlocks, targets, counts
// Overview of operation
// - address is base plus sign-extended 16-bit offset
// - load-use hazard stalls instead of stale data
// - address names least or most significant byte per endianness
// - lanes from size and address bits 1..0
// - illegal size/offset pairs raise address error
// - immediate ops use 16-bit immediate operand
// - multiply goes to separate unit, fills pair
// - product read before ready stalls pipeline
// - one delay slot executes unless a likely branch is untaken
// - jump target is slot pc top plus target<<2
// - register jump uses full register address
// - branch target is slot pc plus offset<<2
// - untaken likely branch nullifies its slot
// - leading ones count, 32 when all set
// - leading zeros count, 32 when all clear
// - signed accumulate into pair, no exception
// - trap ops come from register format only
// - unsigned accumulate into pair, no exception
// - deduct product from pair, no exception
// - low product written to destination register
// - inhibit noop acts as plain noop
`timescale 1ns/1ps
`default_nettype none
module ced_exec
  import ced_pkg::*;
(
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_valid,
  input  wire ced_pkg::ced_op_t          i_op,
  input  wire logic                      i_imm_form,
  input  wire logic                      i_reg_form,
  input  wire logic [ced_pkg::XLEN-1:0]  i_source_a_reg,
  input  wire logic [ced_pkg::XLEN-1:0]  i_source_b_reg,
  input  wire logic [ced_pkg::IMM_W-1:0] i_imm,
  input  wire logic [ced_pkg::REG_IDX_W-1:0] i_src_a_idx,
  input  wire logic [ced_pkg::REG_IDX_W-1:0] i_src_b_idx,
  input  wire logic [ced_pkg::REG_IDX_W-1:0] i_dst_idx,
  input  wire ced_pkg::ced_size_t        i_size,
  input  wire logic                      i_big_endian,
  input  wire ced_pkg::ced_br_t          i_br_kind,
  input  wire logic                      i_br_cond,
  input  wire logic [ced_pkg::JTGT_W-1:0] i_jtarget,
  input  wire logic [ced_pkg::XLEN-1:0]  i_pc,
  output logic                           o_stall,
  output logic                           o_nullify_next,
  output logic                           o_redirect,
  output logic [ced_pkg::XLEN-1:0]       o_target,
  output logic                           o_mem_req,
  output logic                           o_mem_we,
  output logic [ced_pkg::XLEN-1:0]       o_mem_addr,
  output logic [ced_pkg::LANE_W-1:0]     o_mem_lanes,
  output logic                           o_addr_err,
  output logic                           o_trap_illegal,
  output logic                           o_wb_en,
  output logic [ced_pkg::REG_IDX_W-1:0]  o_wb_idx,
  output logic [ced_pkg::XLEN-1:0]       o_wb_data,
  output logic [ced_pkg::XLEN-1:0]       o_alu_b
);
  ////////////////////////////////////////////////////////////////////////
  // functions
  // count of leading ones; leading zeros reuse it on the inverted word
  function automatic logic [CNT_W-1:0] lead_ones(input logic [XLEN-1:0] w);
    logic [CNT_W-1:0] n;
    logic             run;
    n   = '0;
    run = 1'b1;
    for (int i = XLEN - 1; i >= 0; i--)
    begin
      run = run & w[i];
      n   = n + CNT_W'(run);
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // interlock bookkeeping
  ced_mul_if mul ();
  logic                 load_pend_q;
  logic [REG_IDX_W-1:0] load_dst_q;
  logic                 likely_kill_q;
  // low product arrives from the unit when it finishes
  logic                 mulreg_pend_q;
  logic [REG_IDX_W-1:0] mulreg_idx_q;
  wire logic mul_done  = mulreg_pend_q && !mul.busy;

  wire logic is_mem    = (i_op == CED_OP_LOAD) || (i_op == CED_OP_STORE);
  wire logic is_mulop  = (i_op == CED_OP_MACC_S) || (i_op == CED_OP_MACC_U) || (i_op == CED_OP_MDED_S)
                         || (i_op == CED_OP_MDED_U) || (i_op == CED_OP_MULREG);
  wire logic is_prd    = (i_op == CED_OP_RD_UPPER) || (i_op == CED_OP_RD_LOWER);
  // slot instruction of an untaken likely branch is squashed
  wire logic live      = i_valid && !likely_kill_q;
  // load-use: stale register data never reaches the user
  wire logic load_use  = load_pend_q && live && load_dst_q != '0
                         && (load_dst_q == i_src_a_idx || load_dst_q == i_src_b_idx);
  // product reads and results wait until the unit is done
  wire logic prod_wait = live && mul.busy && (is_prd || is_mulop || i_op == CED_OP_MULREG);
  // a finishing low product owns the writeback port for that one cycle
  wire logic wb_op     = (i_op == CED_OP_CLO) || (i_op == CED_OP_CLZ) || is_prd || (i_op == CED_OP_ALU);
  wire logic wb_clash  = live && mul_done && wb_op;
  wire logic stall     = load_use || prod_wait || wb_clash;
  wire logic go        = live && !stall;

  assign o_stall = stall;

  ////////////////////////////////////////////////////////////////////////
  // address forming and lane select
  wire logic [XLEN-1:0] imm_sx   = {{(XLEN-IMM_W){i_imm[IMM_W-1]}}, i_imm};
  wire logic [XLEN-1:0] eff_addr = i_source_a_reg + imm_sx;
  wire logic [2:0]      lo3      = eff_addr[2:0];
  // legal pairs: word 000, triple 00x, half 0x0, byte 0xx
  wire logic addr_ok = (i_size == CED_SZ_WORD)   ? (lo3 == LANE_OFF_ZERO) :
                       (i_size == CED_SZ_TRIPLE) ? (lo3[2:1] == 2'h0) :
                       (i_size == CED_SZ_HALF)   ? (lo3[2] == 1'b0 && lo3[0] == 1'b0) :
                                                   (lo3[2] == 1'b0);
  wire logic [3:0] width_mask = (i_size == CED_SZ_WORD)   ? 4'hf :
                                (i_size == CED_SZ_TRIPLE) ? 4'h7 :
                                (i_size == CED_SZ_HALF)   ? 4'h3 : 4'h1;
  // little endian: lane n is bits 8n+7..8n, the named byte is least significant
  wire logic [3:0] lanes_le = 4'(width_mask << lo3[1:0]);
  // big endian: the named byte is most significant, so lanes mirror
  wire logic [3:0] lanes_be = {lanes_le[0], lanes_le[1], lanes_le[2], lanes_le[3]};
  wire logic addr_err = live && is_mem && !addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // operand select and leading counts
  wire logic [XLEN-1:0] op_b   = i_imm_form ? imm_sx : i_source_b_reg;
  wire logic [CNT_W-1:0] clo_n = lead_ones(i_source_a_reg);
  wire logic [CNT_W-1:0] clz_n = lead_ones(~i_source_a_reg);
  wire logic [XLEN-1:0] cnt_word = {{(XLEN-CNT_W){1'b0}}, (i_op == CED_OP_CLO) ? clo_n : clz_n};
  // traps only come from register format; else flagged illegal
  wire logic trap_bad = live && (i_op == CED_OP_TRAP) && !i_reg_form;

  ////////////////////////////////////////////////////////////////////////
  // branch and jump targets
  wire logic [XLEN-1:0] slot_pc  = i_pc + XLEN'(4);
  wire logic [XLEN-1:0] j_abs    = {slot_pc[XLEN-1 -: PC_HI_W], i_jtarget, 2'b00};
  wire logic [XLEN-1:0] br_tgt   = slot_pc + (imm_sx << ALIGN_SH);
  wire logic taken = (i_br_kind == CED_BR_JABS) || (i_br_kind == CED_BR_JREG)
                     || (((i_br_kind == CED_BR_COND) || (i_br_kind == CED_BR_LIKELY)) && i_br_cond);
  wire logic [XLEN-1:0] tgt_sel  = (i_br_kind == CED_BR_JABS) ? j_abs :
                                   (i_br_kind == CED_BR_JREG) ? i_source_a_reg : br_tgt;
  wire logic likely_miss = go && (i_br_kind == CED_BR_LIKELY) && !i_br_cond;

  ////////////////////////////////////////////////////////////////////////
  // multiplier hand-off: issue and move on
  assign mul.start = go && is_mulop;
  assign mul.op    = i_op;
  assign mul.src_a = i_source_a_reg;
  assign mul.src_b = i_source_b_reg;

  ced_mul_unit u_mul
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .mul       (mul)
  );

  ////////////////////////////////////////////////////////////////////////
  // writeback select
  logic            wb_en_d;
  logic [XLEN-1:0] wb_data_d;
  always_comb
  begin
    wb_en_d   = 1'b0;
    wb_data_d = '0;
    case (i_op)
      CED_OP_CLO, CED_OP_CLZ:
      begin
        wb_en_d   = go;
        wb_data_d = cnt_word;
      end
      CED_OP_RD_UPPER:
      begin
        wb_en_d   = go;
        wb_data_d = mul.pair[2*XLEN-1:XLEN];
      end
      CED_OP_RD_LOWER:
      begin
        wb_en_d   = go;
        wb_data_d = mul.pair[XLEN-1:0];
      end
      CED_OP_ALU:
      begin
        wb_en_d   = go;
        wb_data_d = i_source_a_reg + op_b;
      end
      default: wb_en_d = 1'b0; // plain and inhibit noops change nothing
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs; data outputs come from flops
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      load_pend_q    <= 1'b0;
      load_dst_q     <= '0;
      likely_kill_q  <= 1'b0;
      mulreg_pend_q  <= 1'b0;
      mulreg_idx_q   <= '0;
      o_nullify_next <= 1'b0;
      o_redirect     <= 1'b0;
      o_target       <= '0;
      o_mem_req      <= 1'b0;
      o_mem_we       <= 1'b0;
      o_mem_addr     <= '0;
      o_mem_lanes    <= '0;
      o_addr_err     <= 1'b0;
      o_trap_illegal <= 1'b0;
      o_wb_en        <= 1'b0;
      o_wb_idx       <= '0;
      o_wb_data      <= '0;
      o_alu_b        <= '0;
    end
    else
    begin
      // pending for one cycle only, so the interlock inserts a single cycle
      load_pend_q    <= go && (i_op == CED_OP_LOAD) && addr_ok;
      load_dst_q     <= (go && i_op == CED_OP_LOAD) ? i_dst_idx : load_dst_q;
      // delay slot runs unless a likely branch missed
      likely_kill_q  <= likely_miss ? 1'b1 : (i_valid ? 1'b0 : likely_kill_q);
      o_nullify_next <= likely_miss;
      o_redirect     <= go && taken;
      o_target       <= (go && taken) ? tgt_sel : o_target;
      o_mem_req      <= go && is_mem && addr_ok;
      o_mem_we       <= go && (i_op == CED_OP_STORE) && addr_ok;
      o_mem_addr     <= eff_addr;
      o_mem_lanes    <= i_big_endian ? lanes_be : lanes_le;
      o_addr_err     <= addr_err && !stall;
      o_trap_illegal <= trap_bad && !stall;
      o_alu_b        <= op_b;
      mulreg_pend_q  <= (go && i_op == CED_OP_MULREG) || (mulreg_pend_q && !mul_done);
      mulreg_idx_q   <= (go && i_op == CED_OP_MULREG) ? i_dst_idx : mulreg_idx_q;
      o_wb_en        <= wb_en_d || mul_done;
      o_wb_idx       <= mul_done ? mulreg_idx_q : i_dst_idx;
      o_wb_data      <= mul_done ? mul.low_prod : wb_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_err_no_mem;
    @(posedge i_ref_clk) disable iff (i_rst)
      (go && is_mem && !addr_ok) |=> o_addr_err && !o_mem_req;
  endproperty
  a_err_no_mem: assert property (p_err_no_mem) else $error("address error did not suppress access");

  property p_word_lanes;
    @(posedge i_ref_clk) disable iff (i_rst)
      (go && is_mem && i_size == CED_SZ_WORD && addr_ok) |=> o_mem_lanes == 4'hf;
  endproperty
  a_word_lanes: assert property (p_word_lanes) else $error("word access lanes wrong");

  property p_load_use;
    @(posedge i_ref_clk) disable iff (i_rst)
      (load_pend_q && live && load_dst_q != '0 && load_dst_q == i_src_a_idx) |-> o_stall;
  endproperty
  a_load_use: assert property (p_load_use) else $error("load use not stalled");

  property p_prod_stall;
    @(posedge i_ref_clk) disable iff (i_rst)
      (live && is_prd && mul.busy) |-> o_stall && !wb_en_d;
  endproperty
  a_prod_stall: assert property (p_prod_stall) else $error("product read not stalled");

  property p_clo_all;
    @(posedge i_ref_clk) disable iff (i_rst)
      (go && i_op == CED_OP_CLO && i_source_a_reg == '1) |=> o_wb_en && o_wb_data == XLEN'(32);
  endproperty
  a_clo_all: assert property (p_clo_all) else $error("leading ones of all set not 32");

  property p_clz_all;
    @(posedge i_ref_clk) disable iff (i_rst)
      (go && i_op == CED_OP_CLZ && i_source_a_reg == '0) |=> o_wb_data == XLEN'(32);
  endproperty
  a_clz_all: assert property (p_clz_all) else $error("leading zeros of zero not 32");

  property p_jabs;
    @(posedge i_ref_clk) disable iff (i_rst)
      (go && i_br_kind == CED_BR_JABS) |=> o_redirect && o_target[1:0] == 2'b00
        && o_target[XLEN-1 -: PC_HI_W] == $past(slot_pc[XLEN-1 -: PC_HI_W]);
  endproperty
  a_jabs: assert property (p_jabs) else $error("jump target wrong");

  property p_likely;
    @(posedge i_ref_clk) disable iff (i_rst)
      likely_miss |=> o_nullify_next && !o_redirect;
  endproperty
  a_likely: assert property (p_likely) else $error("likely slot not nullified");

  property p_noop;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_op == CED_OP_INHIBIT && !mul_done) |=> !o_wb_en && !o_mem_req;
  endproperty
  a_noop: assert property (p_noop) else $error("inhibit noop had an effect");

  property p_low_wb;
    @(posedge i_ref_clk) disable iff (i_rst)
      mul_done |=> o_wb_en && o_wb_idx == $past(mulreg_idx_q);
  endproperty
  a_low_wb: assert property (p_low_wb) else $error("low product writeback lost");
endmodule : ced_exec
`default_nettype wire

// file: design/ced_pkg.sv
// shared constants and types for the core execution datapath subset
package ced_pkg;
  localparam int unsigned XLEN       = 32;
  localparam int unsigned IMM_W      = 16;
  localparam int unsigned JTGT_W     = 26;
  localparam int unsigned PC_HI_W    = 4;
  localparam int unsigned ALIGN_SH   = 2;
  localparam int unsigned REG_IDX_W  = 5;
  localparam int unsigned CNT_W      = 6;
  localparam int unsigned LANE_W     = 4;
  localparam int unsigned MUL_LAT    = 3;   // multiplier busy cycles after issue
  localparam logic [1:0]  MUL_CNT_W1 = 2'h3;

  // access sizes
  typedef enum logic [1:0]
  {
    CED_SZ_BYTE   = 2'h0,
    CED_SZ_HALF   = 2'h1,
    CED_SZ_TRIPLE = 2'h2,
    CED_SZ_WORD   = 2'h3
  } ced_size_t;

  // execute operations
  typedef enum logic [3:0]
  {
    CED_OP_NOP      = 4'h0,
    CED_OP_INHIBIT  = 4'h1,  // pipeline_inhibit_noop
    CED_OP_ALU      = 4'h2,
    CED_OP_LOAD     = 4'h3,
    CED_OP_STORE    = 4'h4,
    CED_OP_CLO      = 4'h5,
    CED_OP_CLZ      = 4'h6,
    CED_OP_MACC_S   = 4'h7,
    CED_OP_MACC_U   = 4'h8,
    CED_OP_MDED_S   = 4'h9,
    CED_OP_MDED_U   = 4'ha,
    CED_OP_MULREG   = 4'hb,
    CED_OP_RD_UPPER = 4'hc,
    CED_OP_RD_LOWER = 4'hd,
    CED_OP_TRAP     = 4'he
  } ced_op_t;

  // branch and jump kinds
  typedef enum logic [2:0]
  {
    CED_BR_NONE   = 3'h0,
    CED_BR_JABS   = 3'h1,
    CED_BR_JREG   = 3'h2,
    CED_BR_COND   = 3'h3,
    CED_BR_LIKELY = 3'h4
  } ced_br_t;

  // multiplier sequencer states, gray along idle-busy-done
  typedef enum logic [1:0]
  {
    CED_MS_IDLE = 2'b00,
    CED_MS_BUSY = 2'b01,
    CED_MS_DONE = 2'b11
  } ced_mstate_t;

  localparam logic [2:0] LANE_OFF_ZERO = 3'h0;
endpackage : ced_pkg

// file: design/ced_mul_if.sv
// carrier between the execute stage and the multiply unit
`timescale 1ns/1ps
`default_nettype none
interface ced_mul_if;
  import ced_pkg::*;
  logic                   start;
  ced_op_t                op;
  logic [XLEN-1:0]        src_a;
  logic [XLEN-1:0]        src_b;
  logic                   busy;
  logic [2*XLEN-1:0]      pair;
  logic [XLEN-1:0]        low_prod;

  modport exec (output start, output op, output src_a, output src_b,
                input busy, input pair, input low_prod);
  modport unit (input start, input op, input src_a, input src_b,
                output busy, output pair, output low_prod);
endinterface : ced_mul_if
`default_nettype wire

// file: design/ced_mul_unit.sv
// multi-cycle multiply unit holding the upper/bottom product pair
`timescale 1ns/1ps
`default_nettype none
module ced_mul_unit
  import ced_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  ced_mul_if.unit   mul
);
  ced_mstate_t       state_q;
  logic [1:0]        cnt_q;
  ced_op_t           op_q;
  logic [2*XLEN-1:0] prod_q;
  logic [2*XLEN-1:0] pair_q;
  logic [XLEN-1:0]   low_q;

  // signed and unsigned products formed once at issue
  wire logic signed [2*XLEN-1:0] prod_s = $signed(mul.src_a) * $signed(mul.src_b);
  wire logic        [2*XLEN-1:0] prod_u = {{XLEN{1'b0}}, mul.src_a} * {{XLEN{1'b0}}, mul.src_b};
  wire logic is_signed = (mul.op == CED_OP_MACC_S) || (mul.op == CED_OP_MDED_S)
                         || (mul.op == CED_OP_MULREG);
  wire logic [2*XLEN-1:0] prod_sel = is_signed ? prod_s : prod_u;
  wire logic deduct = (op_q == CED_OP_MDED_S) || (op_q == CED_OP_MDED_U);
  // wraps silently: accumulate and deduct never raise an exception
  wire logic [2*XLEN-1:0] pair_new = deduct ? pair_q - prod_q : pair_q + prod_q;

  assign mul.busy     = (state_q == CED_MS_BUSY);
  assign mul.pair     = pair_q;
  assign mul.low_prod = low_q;

  // sequencer: latency models a separate unit while the pipeline flows
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= CED_MS_IDLE;
      cnt_q   <= 2'h0;
      op_q    <= CED_OP_NOP;
      prod_q  <= '0;
      pair_q  <= '0;
      low_q   <= '0;
    end
    else
    begin
      case (state_q)
        CED_MS_IDLE, CED_MS_DONE:
        begin
          state_q <= CED_MS_IDLE;
          if (mul.start)
          begin
            state_q <= CED_MS_BUSY;
            cnt_q   <= MUL_CNT_W1 - 2'h1;
            op_q    <= mul.op;
            prod_q  <= prod_sel;
          end
        end
        CED_MS_BUSY:
        begin
          if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
          else
          begin
            state_q <= CED_MS_DONE;
            // low product: pair left as is, which is allowed to be undefined
            if (op_q == CED_OP_MULREG)
              low_q <= prod_q[XLEN-1:0];
            else
              pair_q <= pair_new;
          end
        end
        default: state_q <= CED_MS_IDLE;
      endcase
    end
  end

  property p_busy_len;
    @(posedge i_ref_clk) disable iff (i_rst)
      (mul.start && !mul.busy) |=> mul.busy [*3] ##1 !mul.busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("multiplier busy length wrong");

  property p_acc;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_q == CED_MS_BUSY && cnt_q == 2'h0 && op_q == CED_OP_MACC_U)
      |=> pair_q == $past(pair_q) + $past(prod_q);
  endproperty
  a_acc: assert property (p_acc) else $error("unsigned accumulate wrong");
endmodule : ced_mul_unit
`default_nettype wire

// file: verification/ced_mem_model.sv
// far-side memory and fetch model: counts the accesses and redirects it accepts
`timescale 1ns/1ps
`default_nettype none
module ced_mem_model
  import ced_pkg::*;
(
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_mem_req,
  input  wire logic [ced_pkg::LANE_W-1:0] i_mem_lanes,
  input  wire logic                      i_redirect,
  output var  int                        o_req_count,
  output var  int                        o_fetch_count
);
  ////////////////////////////////////////////////////////////////////////////
  // accepts every access at once; a request with no lane would be meaningless
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_req_count   <= 0;
      o_fetch_count <= 0;
    end
    else
    begin
      if (i_mem_req && i_mem_lanes != 4'h0)
        o_req_count <= o_req_count + 1;
      if (i_redirect)
        o_fetch_count <= o_fetch_count + 1;
    end
  end
endmodule // ced_mem_model
`default_nettype wire

// file: verification/tb_core_exec_datapath_subset.sv
// self-checking bench for the execute datapath subset
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_core_exec_datapath_subset;
  import ced_pkg::*;
  logic                 i_ref_clk, i_rst, i_valid, i_imm_form, i_reg_form, i_big_endian, i_br_cond;
  ced_op_t              i_op;
  ced_size_t            i_size;
  ced_br_t              i_br_kind;
  logic [XLEN-1:0]      i_source_a_reg, i_source_b_reg, i_pc, o_target, o_mem_addr, o_wb_data, o_alu_b;
  logic [IMM_W-1:0]     i_imm;
  logic [REG_IDX_W-1:0] i_src_a_idx, i_src_b_idx, i_dst_idx, o_wb_idx;
  logic [JTGT_W-1:0]    i_jtarget;
  logic                 o_stall, o_nullify_next, o_redirect, o_mem_req, o_mem_we, o_addr_err, o_trap_illegal;
  logic                 o_wb_en;
  logic [LANE_W-1:0]    o_mem_lanes;
  int                   bad_count, num_checks, nst, exp_req, req_cnt, fetch_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // design and far-side model
  ced_exec i_dut (.i_ref_clk, .i_rst, .i_valid, .i_op, .i_imm_form, .i_reg_form, .i_source_a_reg,
    .i_source_b_reg, .i_imm, .i_src_a_idx, .i_src_b_idx, .i_dst_idx, .i_size, .i_big_endian, .i_br_kind,
    .i_br_cond, .i_jtarget, .i_pc, .o_stall, .o_nullify_next, .o_redirect, .o_target, .o_mem_req,
    .o_mem_we, .o_mem_addr, .o_mem_lanes, .o_addr_err, .o_trap_illegal, .o_wb_en, .o_wb_idx, .o_wb_data,
    .o_alu_b);
  ced_mem_model i_mem (.i_ref_clk, .i_rst, .i_mem_req(o_mem_req), .i_mem_lanes(o_mem_lanes),
    .i_redirect(o_redirect), .o_req_count(req_cnt), .o_fetch_count(fetch_cnt));

  ////////////////////////////////////////////////////////////////////////////
  // drive at a falling edge, hold through any stall, return after the taking edge
  task automatic issue(input ced_op_t o, input ced_br_t k, input logic [31:0] va, vb);
    int n;
    i_op = o; i_br_kind = k; i_source_a_reg = va; i_source_b_reg = vb; i_valid = 1'b1;
    n = 0;
    #1;
    while (o_stall === 1'b1 && n < 50)
    begin
      @(negedge i_ref_clk); #1; n++;
    end
    nst = n;
    @(negedge i_ref_clk);
  endtask
  task automatic idle();
    i_valid = 1'b0;
    @(negedge i_ref_clk);
  endtask
  function automatic logic [31:0] lead(input logic [31:0] v, input logic x);
    int n;
    n = 0;
    while (n < 32 && v[31 - n] === x) n++;
    return 32'(n);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // every size against every low address for both byte orders, negative offset
  task automatic t_lanes();
    logic [3:0] m;
    logic ok;
    for (int e = 0; e < 2; e++) for (int s = 0; s < 4; s++) for (int f = 0; f < 8; f++)
    begin
      i_big_endian = e[0]; i_size = ced_size_t'(s[1:0]); i_imm = 16'hfff8 + 16'(f);
      ok = (f < 4) && (s == 3 ? f == 0 : s == 2 ? f < 2 : s == 1 ? f[0] == 1'b0 : 1'b1);
      m = 4'(((1 << (s + 1)) - 1) << (f % 4));
      if (i_big_endian) m = {m[0], m[1], m[2], m[3]};
      exp_req += int'(ok);
      issue(f[0] ? CED_OP_STORE : CED_OP_LOAD, CED_BR_NONE, 32'h1000, 32'h0);
      `CHK("addr err", !ok, o_addr_err)
      `CHK("mem req", ok, o_mem_req)
      `CHK("mem we", ok & f[0], o_mem_we)
      if (!ok) `CHK("err wb", 1'b0, o_wb_en)
      if (ok) `CHK("lanes", m, o_mem_lanes)
      if (ok) `CHK("addr", 32'h0ff8 + 32'(f), o_mem_addr)
    end
    idle();
  endtask

  // operand selection, format of traps, load-use interlock
  task automatic t_alu();
    i_imm_form = 1'b1; i_reg_form = 1'b0; i_imm = 16'h1234;
    issue(CED_OP_ALU, CED_BR_NONE, 32'h5, 32'h7);
    `CHK("imm operand", 32'h1234, o_alu_b)
    issue(CED_OP_TRAP, CED_BR_NONE, 32'h0, 32'h0);
    `CHK("trap fmt", 1'b1, o_trap_illegal)
    i_imm_form = 1'b0; i_reg_form = 1'b1;
    issue(CED_OP_ALU, CED_BR_NONE, 32'h5, 32'h7);
    `CHK("reg operand", 32'h7, o_alu_b)
    issue(CED_OP_TRAP, CED_BR_NONE, 32'h0, 32'h0);
    `CHK("trap ok", 1'b0, o_trap_illegal)
    i_size = CED_SZ_WORD; i_big_endian = 1'b0; i_imm = 16'h0; i_dst_idx = 5'h7; exp_req++;
    issue(CED_OP_LOAD, CED_BR_NONE, 32'h2000, 32'h0);
    i_src_b_idx = 5'h7; i_dst_idx = 5'h8;
    issue(CED_OP_ALU, CED_BR_NONE, 32'h1, 32'h2);
    `CHK("load use stall", 1, nst)
    i_src_b_idx = 5'h0;
    issue(CED_OP_ALU, CED_BR_NONE, 32'h1, 32'h2);
    `CHK("no stall", 0, nst)
  endtask

  // a jump, its target and its delay slot
  task automatic jmp(input ced_br_t k, input logic [31:0] va, ex);
    issue(CED_OP_NOP, k, va, 32'h0);
    `CHK("redirect", 1'b1, o_redirect)
    `CHK("target", ex, o_target)
    issue(CED_OP_CLZ, CED_BR_NONE, 32'h0000_ffff, 32'h0); // slot never holds a branch
    `CHK("slot wb", 1'b1, o_wb_en)
    `CHK("slot data", 32'h10, o_wb_data)
  endtask
  task automatic t_ctrl();
    i_pc = 32'ha000_0100; i_jtarget = 26'h3ff_fffe; i_imm = 16'hfffe; i_br_cond = 1'b1; i_dst_idx = 5'h9;
    jmp(CED_BR_JABS, 32'h0, {4'ha, 26'h3ff_fffe, 2'b00});
    jmp(CED_BR_JREG, 32'h1234_5678, 32'h1234_5678);
    jmp(CED_BR_COND, 32'h0, 32'ha000_00fc);
    i_br_cond = 1'b0;
    issue(CED_OP_NOP, CED_BR_LIKELY, 32'h0, 32'h0);
    `CHK("nullify", 1'b1, o_nullify_next)
    `CHK("no redirect", 1'b0, o_redirect)
    issue(CED_OP_CLZ, CED_BR_NONE, 32'h0, 32'h0);
    `CHK("nullified wb", 1'b0, o_wb_en)
    i_br_cond = 1'b1;
    jmp(CED_BR_LIKELY, 32'h0, 32'ha000_00fc);
    // counts; lead() walks bits one by one, unlike any priority encoder
    for (int k = 0; k < 4; k++)
    begin
      i_source_a_reg = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'h0 : (k == 2) ? 32'hfffe_0000 : 32'h0001_0000;
      issue(CED_OP_CLO, CED_BR_NONE, i_source_a_reg, 32'h0);
      `CHK("ones", lead(i_source_a_reg, 1'b1), o_wb_data)
      `CHK("dst", 5'h9, o_wb_idx)
      issue(CED_OP_CLZ, CED_BR_NONE, i_source_a_reg, 32'h0);
      `CHK("zeros", lead(i_source_a_reg, 1'b0), o_wb_data)
    end
    issue(CED_OP_INHIBIT, CED_BR_NONE, 32'h0, 32'h0);
    `CHK("noop wb", 1'b0, o_wb_en)
    `CHK("noop mem", 1'b0, o_mem_req)
  endtask

  // product pair: accumulate and deduct, reads stall until ready
  task automatic t_mul();
    ced_op_t ops[4] = '{CED_OP_MACC_S, CED_OP_MACC_U, CED_OP_MDED_S, CED_OP_MDED_U};
    logic [31:0] va[4] = '{32'hffff_fffe, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
    logic [31:0] vb[4] = '{32'h3, 32'h2, 32'hffff_ffff, 32'h1};
    logic [63:0] pr[4] = '{64'hffff_ffff_ffff_fffa, 64'h1_ffff_fff8, 64'h1_ffff_fff7, 64'hffff_fff8};
    int n;
    for (int k = 0; k < 4; k++)
    begin
      issue(ops[k], CED_BR_NONE, va[k], vb[k]);
      issue(CED_OP_RD_UPPER, CED_BR_NONE, 32'h0, 32'h0);
      `CHK("read stall", 3, nst)
      `CHK("upper", pr[k][63:32], o_wb_data)
      issue(CED_OP_RD_LOWER, CED_BR_NONE, 32'h0, 32'h0);
      `CHK("bottom", pr[k][31:0], o_wb_data)
    end
    issue(CED_OP_MULREG, CED_BR_NONE, 32'hffff_fffd, 32'h5);
    issue(CED_OP_INHIBIT, CED_BR_NONE, 32'h0, 32'h0);
    `CHK("flows on", 0, nst)
    n = 0;
    while (o_wb_en !== 1'b1 && n < 20)
    begin
      idle(); n++;
    end
    `CHK("low latency", MUL_LAT, n)
    `CHK("low dst", 5'h3, o_wb_idx)
    `CHK("low product", 32'hffff_fff1, o_wb_data)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock, watchdog and main sequence
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    #20000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    {i_valid, i_imm_form, i_reg_form, i_big_endian, i_br_cond, i_source_a_reg, i_source_b_reg} = '0;
    {i_pc, i_imm, i_src_a_idx, i_src_b_idx, i_dst_idx, i_jtarget} = '0;
    i_op = CED_OP_NOP; i_size = CED_SZ_WORD; i_br_kind = CED_BR_NONE; i_dst_idx = 5'h3;
    i_rst = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    i_rst = 1'b0;
    @(negedge i_ref_clk);
    t_mul();
    t_lanes();
    t_alu();
    t_ctrl();
    idle();
    `CHK("mem count", exp_req, req_cnt)
    `CHK("fetch count", 4, fetch_cnt)
    report_and_stop();
  end
endmodule // tb_core_exec_datapath_subset
`default_nettype wire
